// *** dv/pstb_bank_monitor.sv ***
`timescale 1ns/1ns
`default_nettype none
module pstb_bank_monitor (
    // Clock and reset
    input wire clk_i,
    input wire reset_i,
    // Command port
    input wire cmd_valid_i,
    input wire cmd_write_i,
    input wire [7:0] cmd_code_i,
    input wire cmd_known_ext_i,
    input wire cmd_data_bad_i,
    input wire cmd_pec_err_i,
    input wire comm_fault_i,
    // Answer and summary
    input wire rd_valid_o,
    input wire rd_two_bytes_o,
    input wire [15:0] rd_data_o,
    input wire [7:0] status_summary_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (reset_i);
    function automatic logic own(input logic [7:0] c);
        own = c inside {[8'h7a:8'h7e], 8'h80, 8'h88, [8'h8b:8'h8d], [8'h94:8'h96]};
    endfunction
    // Bits that may ever be set in each answer
    function automatic logic [15:0] used(input logic [7:0] c);
        used = (c == 8'h7e) ? 16'h00e2 : (c == 8'h80) ? 16'h003b : (c < 8'h7e) ? 16'h00f0 : 16'hffff;
    endfunction
    wire rd_cmd = cmd_valid_i && !cmd_write_i && own(cmd_code_i);
    property p_ans; rd_cmd |=> rd_valid_o && rd_two_bytes_o == ($past(cmd_code_i) > 8'h80); endproperty
    a_ans: assert property (p_ans) else $error("read answer missing or wrong width");
    property p_unused; rd_cmd |=> (rd_data_o & ~used($past(cmd_code_i))) == 16'h0000; endproperty
    a_unused: assert property (p_unused) else $error("unused status bit set");
    property p_unk;
        cmd_valid_i && !own(cmd_code_i) && cmd_code_i != 8'h03 && !cmd_known_ext_i
            |=> !rd_valid_o && status_summary_o[1];
    endproperty
    a_unk: assert property (p_unk) else $error("unknown code not flagged");
    property p_bad; cmd_valid_i && cmd_data_bad_i && own(cmd_code_i) |=> status_summary_o[1]; endproperty
    a_bad: assert property (p_bad) else $error("bad data not flagged");
    property p_pec; cmd_valid_i && cmd_pec_err_i |=> status_summary_o[1]; endproperty
    a_pec: assert property (p_pec) else $error("check failure not flagged");
    property p_wro; cmd_valid_i && cmd_write_i && own(cmd_code_i) |=> !rd_valid_o && status_summary_o[1]; endproperty
    a_wro: assert property (p_wro) else $error("read-only write not flagged");
    property p_cflt; comm_fault_i |=> status_summary_o[1]; endproperty
    a_cflt: assert property (p_cflt) else $error("comm fault not flagged");
    property p_rst; $fell(reset_i) |-> status_summary_o == 8'h00 && !rd_valid_o; endproperty
    a_rst: assert property (p_rst) else $error("outputs not clear after reset");
    property p_latch;
        status_summary_o[1] && !(cmd_valid_i && cmd_write_i && cmd_code_i == 8'h03) |=> status_summary_o[1];
    endproperty
    a_latch: assert property (p_latch) else $error("comm bit dropped without clear");
endmodule // pstb_bank_monitor
bind pstb_bank pstb_bank_monitor pstb_bank_monitor_inst (.clk_i(clk_i), .reset_i(reset_i), .cmd_valid_i(cmd_valid_i),
    .cmd_write_i(cmd_write_i), .cmd_code_i(cmd_code_i), .cmd_known_ext_i(cmd_known_ext_i),
    .cmd_data_bad_i(cmd_data_bad_i), .cmd_pec_err_i(cmd_pec_err_i), .comm_fault_i(comm_fault_i),
    .rd_valid_o(rd_valid_o), .rd_two_bytes_o(rd_two_bytes_o), .rd_data_o(rd_data_o),
    .status_summary_o(status_summary_o));
`default_nettype wire

// *** dv/pstb_bank_tb.sv ***
`timescale 1ns/1ns
`default_nettype none
`include "pstb_defs.vh"
module pstb_bank_tb;
    logic clk_i = 1'b0;
    logic reset_i = 1'b1;
    logic cflt = 1'b0, sync_lost = 1'b0, aux_vld = 1'b0, tlm_vld = 1'b0, conv_en = 1'b0;
    logic [3:0] cnd [4] = '{default: 4'h0};
    logic [15:0] aux_v = 16'h0, aux_lo = 16'h0, aux_hi = 16'h0, vout = 16'h0;
    logic [65:0] mant = 66'h0;
    logic [29:0] expo = 30'h0;
    logic [16:0] v;
    logic [7:0] p;
    logic [7:0] sc [6] = '{8'h7a, 8'h7b, 8'h7c, 8'h7d, 8'h7e, 8'h80};
    logic [7:0] tc [6] = '{8'h88, 8'h8c, 8'h8d, 8'h94, 8'h95, 8'h96};
    logic [19:0] cm [5] = '{20'h50080, 20'h7a240, 20'h8c120, 20'h7a802, 20'h50400};
    wire cv, rdv;
    wire [3:0] cf;
    wire [7:0] cc;
    wire [15:0] rdd;
    int err_count = 0, checks = 0, lo, hi, x;
    always #5 clk_i = ~clk_i;
    pstb_bank pstb_bank_inst (.clk_i(clk_i), .reset_i(reset_i), .cmd_valid_i(cv), .cmd_write_i(cf[3]),
        .cmd_code_i(cc), .cmd_known_ext_i(cf[2]), .cmd_data_bad_i(cf[1]), .cmd_pec_err_i(cf[0]),
        .comm_fault_i(cflt), .rd_valid_o(rdv), .rd_two_bytes_o(), .rd_data_o(rdd), .vout_cond_i(cnd[0]),
        .iout_cond_i(cnd[1]), .vin_cond_i(cnd[2]), .temp_cond_i(cnd[3]), .ext_sync_lost_i(sync_lost),
        .aux_sample_valid_i(aux_vld), .aux_voltage_monitor_i(aux_v), .aux_monitor_low_limit_i(aux_lo),
        .aux_monitor_high_limit_i(aux_hi), .tlm_valid_i(tlm_vld), .converter_en_i(conv_en),
        .l11_mant_i(mant), .l11_exp_i(expo), .vout_l16u_i(vout), .status_summary_o());
    pstb_host pstb_host_inst (.clk_i(clk_i), .rd_valid_i(rdv), .rd_data_i(rdd), .cmd_valid_o(cv),
        .cmd_flags_o(cf), .cmd_code_o(cc));
    task tick(input int n);
        repeat (n) @(posedge clk_i);
        #1;
    endtask
    task chk(input logic [16:0] g, input logic [16:0] e);
        checks++;
        if (g !== e) begin
            err_count++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask
    task rd(input logic [7:0] c, input logic [16:0] e);
        pstb_host_inst.read(c, v);
        chk(v, e);
    endtask
    function automatic logic [7:0] mon(int a, int l, int h);
        mon = {2'b00, 10 * a < 11 * l, 10 * a > 9 * h, 2'b00, a < l, a > h};
    endfunction
    task end_sim;
        $display("Mismatches %0d of %0d checks", err_count, checks);
        if (err_count == 0 && checks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    initial begin
        x = $urandom(32'h3949);
        tick(3);
        reset_i = 1'b0;
        for (int i = 0; i < 6; i++) rd(sc[i], 17'h10000);
        // Condition gone before the read, so only a latched bit shows
        for (int i = 0; i < 12; i++) begin
            p = (i < 4) ? 8'hff : 8'($urandom);
            cnd[i % 4] = p[3:0];
            tick(4);
            cnd[i % 4] = 4'h0;
            tick(4);
            rd(sc[i % 4], {9'h100, p[3:0], 4'h0});
            pstb_host_inst.send(`PSTB_CMD_CLEAR, 4'h8);
            rd(sc[i % 4], 17'h10000);
        end
        sync_lost = 1'b1;
        tick(4);
        sync_lost = 1'b0;
        rd(8'h80, 17'h10008);
        pstb_host_inst.send(`PSTB_CMD_CLEAR, 4'h8);
        for (int i = 0; i < 8; i++) begin
            lo = 1000 + $urandom_range(0, 99);
            hi = lo + 300;
            x = (i == 0) ? lo : lo - 150 + $urandom_range(0, 600);
            {aux_v, aux_lo, aux_hi} = {x[15:0], lo[15:0], hi[15:0]};
            aux_vld = 1'b1;
            tick(1);
            aux_vld = 1'b0;
            rd(8'h80, {9'h100, mon(x, lo, hi)});
            pstb_host_inst.send(`PSTB_CMD_CLEAR, 4'h8);
        end
        for (int i = 0; i < 5; i++) begin
            pstb_host_inst.send(cm[i][19:12], cm[i][11:8]);
            rd(8'h7e, {9'h100, cm[i][7:0]});
            pstb_host_inst.send(`PSTB_CMD_CLEAR, 4'h8);
        end
        cflt = 1'b1;
        tick(1);
        cflt = 1'b0;
        rd(8'h7e, 17'h10002);
        mant = 66'({$urandom, $urandom, $urandom});
        expo = 30'($urandom);
        vout = 16'($urandom);
        {conv_en, tlm_vld} = 2'b11;
        tick(1);
        tlm_vld = 1'b0;
        for (int i = 0; i < 6; i++)
            rd(tc[i], {1'b1, expo[i * 5 +: 5], mant[i * 11 +: 11]});
        rd(8'h8b, {1'b1, vout});
        conv_en = 1'b0;
        tick(2);
        rd(8'h94, 17'h10000);
        rd(8'h95, 17'h10000);
        // Reset in mid-run drops the latched comm bit and the readings
        reset_i = 1'b1;
        tick(3);
        reset_i = 1'b0;
        rd(8'h7e, 17'h10000);
        rd(8'h8b, 17'h10000);
        end_sim;
    end
    initial begin
        #100000;
        err_count++;
        end_sim;
    end
endmodule // pstb_bank_tb
`default_nettype wire

// *** dv/pstb_host.sv ***
`timescale 1ns/1ns
`default_nettype none
module pstb_host (
    // Clock and answer
    input wire logic clk_i,
    input wire logic rd_valid_i,
    input wire logic [15:0] rd_data_i,
    // Command out
    output logic cmd_valid_o,
    output logic [3:0] cmd_flags_o,
    output logic [7:0] cmd_code_o
);
    logic [16:0] ans;
    initial {cmd_valid_o, cmd_flags_o, cmd_code_o} = 13'h0;
    // Flags are {write, known elsewhere, bad data, check error}; call just after an edge
    task send(input logic [7:0] c, input logic [3:0] f);
        {cmd_valid_o, cmd_flags_o, cmd_code_o} = {1'b1, f, c};
        @(posedge clk_i);
        #1;
        // Stale fields scrambled so nothing leans on them
        {cmd_valid_o, cmd_flags_o, cmd_code_o} = {1'b0, ~f, ~c};
        // Answer stands for the cycle after the taking edge
        ans = {rd_valid_i, rd_data_i};
        // Idle edge so the next request never shares this time step
        @(posedge clk_i);
        #1;
    endtask
    task read(input logic [7:0] c, output logic [16:0] v);
        send(c, 4'h0);
        v = ans;
    endtask
endmodule // pstb_host
`default_nettype wire

// *** logic/pstb_bank.v ***
`timescale 1ns/1ns
`default_nettype none

`include "pstb_defs.vh"

// How it works
// RL1 - Output voltage byte: OV/UV fault, warning bits
// RL2 - Output current byte: OC, OC-LV, OC warn, UC
// RL3 - Input byte: input OV/UV fault and warning
// RL4 - Temperature byte: OT/UT fault and warning bits
// RL5 - Unknown command code sets comm bit 7
// RL6 - Bad data on known command sets bit 6
// RL7 - Packet error check failure sets comm bit 5
// RL8 - Write to read-only or other fault: bit 1
// RL9 - Lost external clock sync sets monitor bit 3
// RL10 - Aux voltage beyond limits sets bits 1, 0
// RL11 - Aux warnings ten percent inside limits: bits 5,4
// RL12 - Status bytes read-only, zero after reset
// RL13 - Input voltage reading, two bytes, L11 format
// RL14 - Output voltage reading, two bytes, unsigned L16
// RL15 - Output current reading, two bytes, L11 format
// RL16 - Controller temperature reading, two bytes, L11
// RL17 - Duty and frequency reflect operation while enabled
// RL18 - First phase current at its own code
// RL19 - Any comm bit sets summary bit 1
// RL20 - Status bits latch until host clears them
// RL21 - L11: signed 5-bit exponent over 11-bit mantissa
module pstb_bank (
    // Clock and reset
    input wire clk_i,
    input wire reset_i,
    // Command port from the bus protocol engine
    input wire cmd_valid_i,
    input wire cmd_write_i,
    input wire [7:0] cmd_code_i,
    input wire cmd_known_ext_i,
    input wire cmd_data_bad_i,
    input wire cmd_pec_err_i,
    input wire comm_fault_i,
    // Read answer
    output reg rd_valid_o,
    output reg rd_two_bytes_o,
    output reg [15:0] rd_data_o,
    // Asynchronous fault conditions {hi fault, hi warn, lo warn, lo fault}
    input wire [3:0] vout_cond_i,
    input wire [3:0] iout_cond_i,
    input wire [3:0] vin_cond_i,
    input wire [3:0] temp_cond_i,
    input wire ext_sync_lost_i,
    // Aux voltage monitor, same clock
    input wire aux_sample_valid_i,
    input wire [15:0] aux_voltage_monitor_i,
    input wire [15:0] aux_monitor_low_limit_i,
    input wire [15:0] aux_monitor_high_limit_i,
    // Telemetry, same clock
    input wire tlm_valid_i,
    input wire converter_en_i,
    input wire [`PSTB_L11_CHANNELS*`PSTB_MANT_W-1:0] l11_mant_i,
    input wire [`PSTB_L11_CHANNELS*`PSTB_EXP_W-1:0] l11_exp_i,
    input wire [15:0] vout_l16u_i,
    // Summary
    output reg [7:0] status_summary_o
);

    // L11 channel slots
    localparam CH_VIN = 0;
    localparam CH_IOUT = 1;
    localparam CH_TEMP = 2;
    localparam CH_DUTY = 3;
    localparam CH_FREQ = 4;
    localparam CH_PH0 = 5;

    reg [16:0] sync1_q;
    reg [16:0] sync2_q;
    reg [7:0] vout_st_q;
    reg [7:0] iout_st_q;
    reg [7:0] vin_st_q;
    reg [7:0] temp_st_q;
    reg [7:0] cml_st_q;
    reg [7:0] mon_st_q;
    reg [15:0] vout_rd_q;
    wire [16*`PSTB_L11_CHANNELS-1:0] l11_rd_q;
    reg [7:0] vout_st_d;
    reg [7:0] iout_st_d;
    reg [7:0] vin_st_d;
    reg [7:0] temp_st_d;
    reg [7:0] cml_st_d;
    reg [7:0] mon_st_d;
    reg [7:0] cml_set;
    reg [7:0] mon_set;
    reg code_known;
    reg code_owned;
    reg [15:0] rd_data_d;
    reg rd_two_d;
    reg [7:0] summary_d;
    wire clear_req;
    wire [19:0] aux_x10;
    wire [19:0] low_x11;
    wire [19:0] high_x9;
    wire [19:0] low_x10;
    wire [19:0] high_x10;
    wire [7:0] vout_set;
    wire [7:0] iout_set;
    wire [7:0] vin_set;
    wire [7:0] temp_set;

    // Fault conditions come from the analog side, so sync before use
    always @(posedge clk_i) begin
        if (reset_i) begin
            sync1_q <= 17'h00000;
            sync2_q <= 17'h00000;
        end else begin
            sync1_q <= {ext_sync_lost_i, temp_cond_i, vin_cond_i, iout_cond_i, vout_cond_i};
            sync2_q <= sync1_q;
        end
    end

    // Synced levels land in the upper nibble; the lower nibble never sets
    assign vout_set = {sync2_q[3:0], 4'h0}; // [RL1]
    assign iout_set = {sync2_q[7:4], 4'h0}; // [RL2]
    assign vin_set = {sync2_q[11:8], 4'h0}; // [RL3]
    assign temp_set = {sync2_q[15:12], 4'h0}; // [RL4]

    // Limits scaled so the ten percent window needs no divider
    assign aux_x10 = aux_voltage_monitor_i * `PSTB_WARN_SCALE;
    assign low_x10 = aux_monitor_low_limit_i * `PSTB_WARN_SCALE;
    assign high_x10 = aux_monitor_high_limit_i * `PSTB_WARN_SCALE;
    assign low_x11 = aux_monitor_low_limit_i * `PSTB_UV_WARN_MUL;
    assign high_x9 = aux_monitor_high_limit_i * `PSTB_OV_WARN_MUL;

    assign clear_req = cmd_valid_i && cmd_write_i && (cmd_code_i == `PSTB_CMD_CLEAR);

    // Command decode and read mux
    always @* begin
        code_owned = 1'b1;
        rd_two_d = 1'b1;
        rd_data_d = 16'h0000;
        case (cmd_code_i)
            `PSTB_CMD_VOUT_STATUS: begin
                rd_two_d = 1'b0;
                rd_data_d = {8'h00, vout_st_q}; // [RL12]
            end
            `PSTB_CMD_IOUT_STATUS: begin
                rd_two_d = 1'b0;
                rd_data_d = {8'h00, iout_st_q}; // [RL12]
            end
            `PSTB_CMD_INPUT_STATUS: begin
                rd_two_d = 1'b0;
                rd_data_d = {8'h00, vin_st_q}; // [RL12]
            end
            `PSTB_CMD_TEMP_STATUS: begin
                rd_two_d = 1'b0;
                rd_data_d = {8'h00, temp_st_q}; // [RL12]
            end
            `PSTB_CMD_CML_STATUS: begin
                rd_two_d = 1'b0;
                rd_data_d = {8'h00, cml_st_q}; // [RL12]
            end
            `PSTB_CMD_MON_STATUS: begin
                rd_two_d = 1'b0;
                rd_data_d = {8'h00, mon_st_q}; // [RL12]
            end
            `PSTB_CMD_VIN_READ: begin
                rd_data_d = l11_rd_q[16*CH_VIN +: 16]; // [RL13]
            end
            `PSTB_CMD_VOUT_READ: begin
                rd_data_d = vout_rd_q; // [RL14]
            end
            `PSTB_CMD_IOUT_READ: begin
                rd_data_d = l11_rd_q[16*CH_IOUT +: 16]; // [RL15]
            end
            `PSTB_CMD_TEMP_READ: begin
                rd_data_d = l11_rd_q[16*CH_TEMP +: 16]; // [RL16]
            end
            `PSTB_CMD_DUTY_READ: begin
                rd_data_d = l11_rd_q[16*CH_DUTY +: 16]; // [RL17]
            end
            `PSTB_CMD_FREQ_READ: begin
                rd_data_d = l11_rd_q[16*CH_FREQ +: 16]; // [RL17]
            end
            `PSTB_CMD_PH0_READ: begin
                rd_data_d = l11_rd_q[16*CH_PH0 +: 16]; // [RL18]
            end
            `PSTB_CMD_CLEAR: begin
                rd_two_d = 1'b0;
            end
            default: begin
                code_owned = 1'b0;
                rd_two_d = 1'b0;
            end
        endcase
        code_known = code_owned || cmd_known_ext_i;
    end

    // Events for the communication / logic byte
    always @* begin
        cml_set = 8'h00;
        if (cmd_valid_i) begin
            cml_set[`PSTB_CML_BAD_CMD] = !code_known; // [RL5]
            cml_set[`PSTB_CML_BAD_DATA] = code_known && cmd_data_bad_i; // [RL6]
            cml_set[`PSTB_CML_PEC] = cmd_pec_err_i; // [RL7]
            // Only this block's own codes are known to be read-only
            cml_set[`PSTB_CML_OTHER] = code_owned && cmd_write_i && !clear_req; // [RL8]
        end
        if (comm_fault_i) begin
            cml_set[`PSTB_CML_OTHER] = 1'b1; // [RL8]
        end
    end

    // Events for the monitor and sync byte
    always @* begin
        mon_set = 8'h00;
        mon_set[`PSTB_MON_SYNC] = sync2_q[16]; // [RL9]
        if (aux_sample_valid_i) begin
            mon_set[`PSTB_MON_UV_FAULT] = aux_x10 < low_x10; // [RL10]
            mon_set[`PSTB_MON_OV_FAULT] = aux_x10 > high_x10; // [RL10]
            mon_set[`PSTB_MON_UV_WARN] = aux_x10 < low_x11; // [RL11]
            mon_set[`PSTB_MON_OV_WARN] = aux_x10 > high_x9; // [RL11]
        end
    end

    // Sticky status: a set in the clearing cycle survives the clear
    always @* begin
        vout_st_d = clear_req ? `PSTB_STATUS_RST : vout_st_q;
        iout_st_d = clear_req ? `PSTB_STATUS_RST : iout_st_q;
        vin_st_d = clear_req ? `PSTB_STATUS_RST : vin_st_q;
        temp_st_d = clear_req ? `PSTB_STATUS_RST : temp_st_q;
        cml_st_d = clear_req ? `PSTB_STATUS_RST : cml_st_q;
        mon_st_d = clear_req ? `PSTB_STATUS_RST : mon_st_q;
        vout_st_d = vout_st_d | vout_set; // [RL1] [RL20]
        iout_st_d = iout_st_d | iout_set; // [RL2] [RL20]
        vin_st_d = vin_st_d | vin_set; // [RL3] [RL20]
        temp_st_d = temp_st_d | temp_set; // [RL4] [RL20]
        cml_st_d = cml_st_d | cml_set; // [RL20]
        mon_st_d = mon_st_d | mon_set; // [RL20]
    end

    always @(posedge clk_i) begin
        if (reset_i) begin
            vout_st_q <= `PSTB_STATUS_RST; // [RL12]
        end else begin
            vout_st_q <= vout_st_d;
        end
    end

    always @(posedge clk_i) begin
        if (reset_i) begin
            iout_st_q <= `PSTB_STATUS_RST; // [RL12]
        end else begin
            iout_st_q <= iout_st_d;
        end
    end

    always @(posedge clk_i) begin
        if (reset_i) begin
            vin_st_q <= `PSTB_STATUS_RST; // [RL12]
        end else begin
            vin_st_q <= vin_st_d;
        end
    end

    always @(posedge clk_i) begin
        if (reset_i) begin
            temp_st_q <= `PSTB_STATUS_RST; // [RL12]
        end else begin
            temp_st_q <= temp_st_d;
        end
    end

    always @(posedge clk_i) begin
        if (reset_i) begin
            cml_st_q <= `PSTB_STATUS_RST; // [RL12]
        end else begin
            cml_st_q <= cml_st_d;
        end
    end

    always @(posedge clk_i) begin
        if (reset_i) begin
            mon_st_q <= `PSTB_STATUS_RST; // [RL12]
        end else begin
            mon_st_q <= mon_st_d;
        end
    end

    // Telemetry capture, one L11 channel per slot
    genvar ch;
    generate
        for (ch = 0; ch < `PSTB_L11_CHANNELS; ch = ch + 1) begin : g_l11
            wire is_switching;
            wire hold_zero;
            // One register per slot keeps every bit to a single driver
            reg [15:0] slot_q;
            assign is_switching = (ch == CH_DUTY) || (ch == CH_FREQ);
            // Duty and frequency mean nothing with the converter off
            assign hold_zero = is_switching && !converter_en_i; // [RL17]
            always @(posedge clk_i) begin
                if (reset_i) begin
                    slot_q <= `PSTB_READ_RST;
                end else if (hold_zero) begin
                    slot_q <= `PSTB_READ_RST; // [RL17]
                end else if (tlm_valid_i) begin
                    slot_q <= {l11_exp_i[`PSTB_EXP_W*ch +: `PSTB_EXP_W],
                        l11_mant_i[`PSTB_MANT_W*ch +: `PSTB_MANT_W]}; // [RL21]
                end
            end
            assign l11_rd_q[16*ch +: 16] = slot_q;
        end
    endgenerate

    always @(posedge clk_i) begin
        if (reset_i) begin
            vout_rd_q <= `PSTB_READ_RST;
        end else if (tlm_valid_i) begin
            vout_rd_q <= vout_l16u_i; // [RL14]
        end
    end

    // Summary built from the next status so it never lags the bytes
    always @* begin
        summary_d = 8'h00;
        summary_d[`PSTB_SUM_VOUT_OV] = vout_st_d[`PSTB_HI_FAULT];
        summary_d[`PSTB_SUM_IOUT_OC] = iout_st_d[`PSTB_HI_FAULT];
        summary_d[`PSTB_SUM_VIN_UV] = vin_st_d[`PSTB_LO_FAULT];
        summary_d[`PSTB_SUM_TEMP] = |temp_st_d;
        summary_d[`PSTB_SUM_CML] = |cml_st_d; // [RL19]
    end

    // Answer port
    always @(posedge clk_i) begin
        if (reset_i) begin
            rd_valid_o <= 1'b0;
            rd_two_bytes_o <= 1'b0;
            rd_data_o <= 16'h0000;
            status_summary_o <= 8'h00;
        end else begin
            rd_valid_o <= cmd_valid_i && !cmd_write_i && code_owned && (cmd_code_i != `PSTB_CMD_CLEAR);
            rd_two_bytes_o <= rd_two_d;
            rd_data_o <= rd_data_d;
            status_summary_o <= summary_d;
        end
    end

endmodule // pstb_bank

`default_nettype wire

// *** shared/pstb_defs.vh ***
`ifndef PSTB_DEFS_VH
`define PSTB_DEFS_VH

// Command codes of the status and telemetry registers
`define PSTB_CMD_CLEAR 8'h03
`define PSTB_CMD_VOUT_STATUS 8'h7a
`define PSTB_CMD_IOUT_STATUS 8'h7b
`define PSTB_CMD_INPUT_STATUS 8'h7c
`define PSTB_CMD_TEMP_STATUS 8'h7d
`define PSTB_CMD_CML_STATUS 8'h7e
`define PSTB_CMD_MON_STATUS 8'h80
`define PSTB_CMD_VIN_READ 8'h88
`define PSTB_CMD_VOUT_READ 8'h8b
`define PSTB_CMD_IOUT_READ 8'h8c
`define PSTB_CMD_TEMP_READ 8'h8d
`define PSTB_CMD_DUTY_READ 8'h94
`define PSTB_CMD_FREQ_READ 8'h95
`define PSTB_CMD_PH0_READ 8'h96

// Reset values
`define PSTB_STATUS_RST 8'h00
`define PSTB_READ_RST 16'h0000

// Bit positions shared by the four category bytes
`define PSTB_HI_FAULT 7
`define PSTB_HI_WARN 6
`define PSTB_LO_WARN 5
`define PSTB_LO_FAULT 4

// Communication / logic byte
`define PSTB_CML_BAD_CMD 7
`define PSTB_CML_BAD_DATA 6
`define PSTB_CML_PEC 5
`define PSTB_CML_OTHER 1

// Monitor and sync byte
`define PSTB_MON_UV_WARN 5
`define PSTB_MON_OV_WARN 4
`define PSTB_MON_SYNC 3
`define PSTB_MON_UV_FAULT 1
`define PSTB_MON_OV_FAULT 0

// Summary byte
`define PSTB_SUM_VOUT_OV 5
`define PSTB_SUM_IOUT_OC 4
`define PSTB_SUM_VIN_UV 3
`define PSTB_SUM_TEMP 2
`define PSTB_SUM_CML 1

// Warning window: ten percent inside the fault limits
`define PSTB_WARN_SCALE 5'd10
`define PSTB_UV_WARN_MUL 5'd11
`define PSTB_OV_WARN_MUL 5'd9

// Linear format layout
`define PSTB_L11_CHANNELS 6
`define PSTB_MANT_W 11
`define PSTB_EXP_W 5

`endif
